// [hdl/lfs_sequencer.sv]
// Fault supervision and gate sequencing of a quasi-resonant LED driver
// ----------------------------------------------------------------
// What this block does
// - Start pulsing only after brown-out turn-on level
// - Stop switching below brown-out turn-off level
// - High line waits for second valley
// - Light load skips additional valleys
// - Valley index locked until line/setpoint change
// - Foldback ramps reference down, floor at half
// - Second thermal threshold stops switching as fault
// - Shutdown pin pulled low forces thermal fault
// - Shutdown pin driven high is overvoltage fault
// - Pin faults latch off or auto-recover after delay
// - Peak current limit ends pulse every cycle
// - Four consecutive 150% cycles stop switching
// - Zero-crossing low for interval means short
// - Supply overvoltage shuts down, waits recovery delay
// - Thermal detection blanked after start-up
// - Shutdown pin faults confirmed after persistence delay
// - Low line after blanking, high line immediately
// ----------------------------------------------------------------
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module lfs_sequencer #(
  parameter logic [31:0] BO_BLANK  = 32'(lfs_pkg::BO_BLANK_CYC),
  parameter logic [31:0] LL_BLANK  = 32'(lfs_pkg::LL_BLANK_CYC),
  parameter logic [31:0] SD_DELAY  = 32'(lfs_pkg::SD_DELAY_CYC),
  parameter logic [31:0] SHORT_T   = 32'(lfs_pkg::SHORT_CYC),
  parameter logic [31:0] RECOVERY  = 32'(lfs_pkg::RECOVERY_CYC),
  parameter logic [31:0] OTP_BLANK = 32'(lfs_pkg::OTP_BLANK_CYC),
  parameter logic [31:0] MAX_ON    = 32'(lfs_pkg::MAX_ON_CYC)
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire lfs_pkg::lfs_cmp_t cmp_in,
  output logic                  gate_drive,
  output logic [7:0]            current_ref,
  output logic                  irq,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);

  // ----------------------------------------------------------------
  // Input qualification
  // ----------------------------------------------------------------
  lfs_pkg::lfs_cmp_t cmp;
  logic [lfs_pkg::NUM_Q-1:0] q_cond;
  logic [31:0]               q_limit [lfs_pkg::NUM_Q];
  logic [lfs_pkg::NUM_Q-1:0] q_hit;

  lfs_sync #(
    .W ($bits(lfs_pkg::lfs_cmp_t))
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (cmp_in),
    .q       (cmp)
  );

  assign q_cond[lfs_pkg::Q_BO]     = cmp.bo_off_below;
  assign q_cond[lfs_pkg::Q_LL]     = cmp.ll_below;
  assign q_cond[lfs_pkg::Q_TRIP]   = cmp.sd_trip_below;
  assign q_cond[lfs_pkg::Q_OVP]    = cmp.sd_ovp_above;
  assign q_cond[lfs_pkg::Q_SHORT]  = !cmp.zc_above_short;
  assign q_limit[lfs_pkg::Q_BO]    = BO_BLANK;
  assign q_limit[lfs_pkg::Q_LL]    = LL_BLANK;
  assign q_limit[lfs_pkg::Q_TRIP]  = SD_DELAY;
  assign q_limit[lfs_pkg::Q_OVP]   = SD_DELAY;
  assign q_limit[lfs_pkg::Q_SHORT] = SHORT_T;

  for (genvar i = 0; i < lfs_pkg::NUM_Q; i++) begin : g_q
    lfs_persist u_persist (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cond    (q_cond[i]),
      .limit   (q_limit[i]),
      .hit     (q_hit[i])
    );
  end

  // ----------------------------------------------------------------
  // Line supervision
  // ----------------------------------------------------------------
  logic bo_ok_q;
  logic high_line_q;
  logic high_line_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bo_ok_q <= 1'b0;
    end else if (q_hit[lfs_pkg::Q_BO]) begin
      bo_ok_q <= 1'b0;
    end else if (cmp.bo_on_above) begin
      bo_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_line_q      <= 1'b0;
      high_line_prev_q <= 1'b0;
    end else begin
      high_line_prev_q <= high_line_q;
      if (cmp.hl_above) begin
        high_line_q <= 1'b1;
      end else if (q_hit[lfs_pkg::Q_LL]) begin
        high_line_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Thermal blanking and foldback
  // ----------------------------------------------------------------
  logic [31:0] otp_blank_q;
  logic        otp_armed;
  logic [31:0] fold_cnt_q;
  logic [7:0]  ref_q;
  logic        fold_active;

  // Lets a filter cap on the pin settle before thermal faults count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      otp_blank_q <= 32'h0000_0000;
    end else if (!otp_armed) begin
      otp_blank_q <= otp_blank_q + 32'h0000_0001;
    end
  end
  assign otp_armed = (otp_blank_q >= OTP_BLANK);

  assign fold_active = cmp.sd_fold_below;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fold_cnt_q <= 32'h0000_0000;
      ref_q      <= lfs_pkg::REF_FULL;
    end else if (fold_cnt_q + 32'h0000_0001 >= 32'(lfs_pkg::FOLD_STEP_CYC)) begin
      fold_cnt_q <= 32'h0000_0000;
      if (fold_active && ref_q > lfs_pkg::REF_FLOOR) begin
        ref_q <= ref_q - 8'h01;
      end else if (!fold_active && ref_q < lfs_pkg::REF_FULL) begin
        ref_q <= ref_q + 8'h01;
      end
    end else begin
      fold_cnt_q <= fold_cnt_q + 32'h0000_0001;
    end
  end
  assign current_ref = ref_q;

  // ----------------------------------------------------------------
  // Valley selection
  // ----------------------------------------------------------------
  logic [3:0] val_target;
  logic [3:0] val_idx_q;
  logic [7:0] ref_lock_q;
  logic [7:0] ref_diff;
  logic       relock;
  lfs_pkg::lfs_state_t state_q;

  always_comb begin
    val_target = high_line_q ? lfs_pkg::VAL_HIGH : lfs_pkg::VAL_LOW;
    if (cmp.light_load) begin
      val_target = val_target + lfs_pkg::VAL_LIGHT;
    end
    if (fold_active) begin
      val_target = val_target + lfs_pkg::VAL_FOLD;
    end
  end

  assign ref_diff = (ref_q > ref_lock_q) ? ref_q - ref_lock_q : ref_lock_q - ref_q;
  assign relock   = (high_line_q != high_line_prev_q) || (ref_diff >= lfs_pkg::REF_DELTA)
                    || (state_q == lfs_pkg::ST_IDLE);

  // Locking avoids hopping between valleys and the audible noise it causes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      val_idx_q  <= lfs_pkg::VAL_LOW;
      ref_lock_q <= lfs_pkg::REF_FULL;
    end else if (relock) begin
      val_idx_q  <= val_target;
      ref_lock_q <= ref_q;
    end
  end

  // ----------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------
  logic       running;
  logic       otp_fault;
  logic       ovp_fault;
  logic       short_fault;
  logic       cs_fault;
  logic       any_fault;
  logic       latch_kind;
  logic       auto_q;
  logic [2:0] cs150_cnt_q;
  logic       cs150_seen_q;
  logic       pulse_end;

  assign running     = (state_q == lfs_pkg::ST_WAIT_VALLEY) || (state_q == lfs_pkg::ST_DRIVE);
  assign otp_fault   = otp_armed && q_hit[lfs_pkg::Q_TRIP];
  assign ovp_fault   = q_hit[lfs_pkg::Q_OVP];
  assign short_fault = q_hit[lfs_pkg::Q_SHORT];
  assign cs_fault    = (cs150_cnt_q >= lfs_pkg::CS150_LIMIT);
  assign any_fault   = running && (otp_fault || ovp_fault || short_fault || cs_fault
                                   || cmp.vcc_ovp);
  // Supply overvoltage always retries; the others follow the variant
  assign latch_kind  = !auto_q && (otp_fault || ovp_fault || short_fault || cs_fault);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs150_cnt_q  <= 3'h0;
      cs150_seen_q <= 1'b0;
    end else if (!running) begin
      cs150_cnt_q  <= 3'h0;
      cs150_seen_q <= 1'b0;
    end else if (pulse_end) begin
      cs150_seen_q <= 1'b0;
      if (cs150_seen_q || cmp.cs_150) begin
        cs150_cnt_q <= (cs150_cnt_q < lfs_pkg::CS150_LIMIT) ? cs150_cnt_q + 3'h1
                                                           : cs150_cnt_q;
      end else begin
        cs150_cnt_q <= 3'h0;
      end
    end else if (state_q == lfs_pkg::ST_DRIVE && cmp.cs_150) begin
      cs150_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [31:0] tmr_q;
  logic        valley_prev_q;
  logic        valley_edge;
  logic [3:0]  valley_cnt_q;
  logic        gate_q;
  logic        restart_ev;

  assign valley_edge = cmp.valley_clock && !valley_prev_q;
  assign pulse_end   = (state_q == lfs_pkg::ST_DRIVE)
                       && (cmp.cs_limit || cmp.cs_setpoint || tmr_q >= MAX_ON);
  assign restart_ev  = (state_q == lfs_pkg::ST_RECOVER) && (tmr_q + 32'h0000_0001 >= RECOVERY);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valley_prev_q <= 1'b0;
    end else begin
      valley_prev_q <= cmp.valley_clock;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= lfs_pkg::ST_IDLE;
      tmr_q        <= 32'h0000_0000;
      valley_cnt_q <= 4'h0;
      gate_q       <= 1'b0;
    end else begin
      case (state_q)
        lfs_pkg::ST_IDLE: begin
          gate_q <= 1'b0;
          if (bo_ok_q) begin
            state_q      <= lfs_pkg::ST_WAIT_VALLEY;
            valley_cnt_q <= 4'h0;
          end
        end
        lfs_pkg::ST_WAIT_VALLEY: begin
          if (any_fault) begin
            state_q <= latch_kind ? lfs_pkg::ST_LATCHED : lfs_pkg::ST_RECOVER;
            tmr_q   <= 32'h0000_0000;
          end else if (!bo_ok_q) begin
            state_q <= lfs_pkg::ST_IDLE;
          end else if (valley_edge) begin
            if (valley_cnt_q + 4'h1 >= val_idx_q) begin
              state_q <= lfs_pkg::ST_DRIVE;
              gate_q  <= 1'b1;
              tmr_q   <= 32'h0000_0000;
            end else begin
              valley_cnt_q <= valley_cnt_q + 4'h1;
            end
          end
        end
        lfs_pkg::ST_DRIVE: begin
          tmr_q <= tmr_q + 32'h0000_0001;
          if (any_fault) begin
            state_q <= latch_kind ? lfs_pkg::ST_LATCHED : lfs_pkg::ST_RECOVER;
            gate_q  <= 1'b0;
            tmr_q   <= 32'h0000_0000;
          end else if (!bo_ok_q) begin
            state_q <= lfs_pkg::ST_IDLE;
            gate_q  <= 1'b0;
          end else if (pulse_end) begin
            state_q      <= lfs_pkg::ST_WAIT_VALLEY;
            gate_q       <= 1'b0;
            valley_cnt_q <= 4'h0;
          end
        end
        lfs_pkg::ST_RECOVER: begin
          gate_q <= 1'b0;
          tmr_q  <= tmr_q + 32'h0000_0001;
          if (restart_ev) begin
            state_q <= lfs_pkg::ST_IDLE;
          end
        end
        lfs_pkg::ST_LATCHED: begin
          gate_q <= 1'b0;
        end
        default: begin
          state_q <= lfs_pkg::ST_IDLE;
          gate_q  <= 1'b0;
        end
      endcase
    end
  end
  assign gate_drive = gate_q;

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [lfs_pkg::NUM_EV-1:0] ev;
  logic [lfs_pkg::NUM_EV-1:0] int_stat_q;
  logic [lfs_pkg::NUM_EV-1:0] int_en_q;
  logic [lfs_pkg::NUM_EV-1:0] int_clr;

  always_comb begin
    ev = '0;
    ev[lfs_pkg::EV_BROWNOUT]  = running && !bo_ok_q && !any_fault;
    ev[lfs_pkg::EV_OTP]       = any_fault && otp_fault;
    ev[lfs_pkg::EV_SD_OVP]    = any_fault && ovp_fault;
    ev[lfs_pkg::EV_CS_SHORT]  = any_fault && cs_fault;
    ev[lfs_pkg::EV_AUX_SHORT] = any_fault && short_fault;
    ev[lfs_pkg::EV_VCC_OVP]   = any_fault && cmp.vcc_ovp;
    ev[lfs_pkg::EV_RESTART]   = restart_ev;
  end

  // A new event outranks a clear landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_q <= '0;
    end else begin
      int_stat_q <= (int_stat_q & ~int_clr) | ev;
    end
  end
  assign irq = |(int_stat_q & int_en_q);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        do_write;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] status_word;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign do_write      = aw_have_q && w_have_q && !bvalid_q;
  assign int_clr       = (do_write && awaddr_q == lfs_pkg::ADDR_INT_CLR && wstrb_q[0])
                         ? wdata_q[lfs_pkg::NUM_EV-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= lfs_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        case (awaddr_q)
          lfs_pkg::ADDR_CTRL,
          lfs_pkg::ADDR_STATUS,
          lfs_pkg::ADDR_INT_STAT,
          lfs_pkg::ADDR_INT_CLR,
          lfs_pkg::ADDR_INT_EN: bresp_q <= lfs_pkg::RESP_OKAY;
          default:              bresp_q <= lfs_pkg::RESP_SLVERR;
        endcase
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Variant and enables change only by a write with the low lane strobed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_q   <= lfs_pkg::CTRL_AUTO_RST;
      int_en_q <= '0;
    end else if (do_write && wstrb_q[0]) begin
      if (awaddr_q == lfs_pkg::ADDR_CTRL) begin
        auto_q <= wdata_q[lfs_pkg::CTRL_AUTO_BIT];
      end
      if (awaddr_q == lfs_pkg::ADDR_INT_EN) begin
        int_en_q <= wdata_q[lfs_pkg::NUM_EV-1:0];
      end
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[lfs_pkg::ST_STATE_LSB +: 3] = state_q;
    status_word[lfs_pkg::ST_HL_BIT]         = high_line_q;
    status_word[lfs_pkg::ST_BO_BIT]         = bo_ok_q;
    status_word[lfs_pkg::ST_FOLD_BIT]       = fold_active;
    status_word[lfs_pkg::ST_VAL_LSB +: 4]   = val_idx_q;
    status_word[lfs_pkg::ST_REF_LSB +: 8]   = ref_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= lfs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= lfs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        lfs_pkg::ADDR_CTRL:     rdata_q <= {31'h0, auto_q};
        lfs_pkg::ADDR_STATUS:   rdata_q <= status_word;
        lfs_pkg::ADDR_INT_STAT: rdata_q <= {25'h0, int_stat_q};
        lfs_pkg::ADDR_INT_CLR:  rdata_q <= 32'h0000_0000;
        lfs_pkg::ADDR_INT_EN:   rdata_q <= {25'h0, int_en_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= lfs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// [hdl/lfs_pkg.sv]
// Constants and types of the LED fault sequencer
package lfs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1_000;
  localparam int unsigned BO_BLANK_MS   = 25;
  localparam int unsigned BO_BLANK_CYC  = BO_BLANK_MS * CYC_PER_MS;
  localparam int unsigned LL_BLANK_MS   = 25;
  localparam int unsigned LL_BLANK_CYC  = LL_BLANK_MS * CYC_PER_MS;
  localparam int unsigned SD_DELAY_NS   = 30_000;
  localparam int unsigned SD_DELAY_CYC  = SD_DELAY_NS * CYC_PER_US / 1_000;
  localparam int unsigned SHORT_MS      = 90;
  localparam int unsigned SHORT_CYC     = SHORT_MS * CYC_PER_MS;
  localparam int unsigned RECOVERY_S    = 4;
  localparam int unsigned RECOVERY_CYC  = RECOVERY_S * CLK_HZ;
  localparam int unsigned OTP_BLANK_US  = 250;
  localparam int unsigned OTP_BLANK_CYC = OTP_BLANK_US * CYC_PER_US;
  localparam int unsigned MAX_ON_US     = 40;
  localparam int unsigned MAX_ON_CYC    = MAX_ON_US * CYC_PER_US;
  localparam int unsigned FOLD_STEP_CYC = 2_000;

  // ----------------------------------------------------------------
  // Current reference, valley selection and 150% cycle limit
  // ----------------------------------------------------------------
  localparam logic [7:0] REF_FULL    = 8'hC8;
  localparam logic [7:0] REF_FLOOR   = 8'h64;
  localparam logic [7:0] REF_DELTA   = 8'h10;
  localparam logic [3:0] VAL_LOW     = 4'h1;
  localparam logic [3:0] VAL_HIGH    = 4'h2;
  localparam logic [3:0] VAL_LIGHT   = 4'h2;
  localparam logic [3:0] VAL_FOLD    = 4'h1;
  localparam logic [2:0] CS150_LIMIT = 3'h4;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_CLR  = 8'h0C;
  localparam logic [7:0] ADDR_INT_EN   = 8'h10;
  localparam int unsigned CTRL_AUTO_BIT = 0;
  localparam logic        CTRL_AUTO_RST = 1'b0;
  localparam int unsigned ST_STATE_LSB  = 0;
  localparam int unsigned ST_HL_BIT     = 3;
  localparam int unsigned ST_BO_BIT     = 4;
  localparam int unsigned ST_FOLD_BIT   = 5;
  localparam int unsigned ST_VAL_LSB    = 8;
  localparam int unsigned ST_REF_LSB    = 16;
  localparam int unsigned NUM_EV        = 7;
  localparam int unsigned EV_BROWNOUT   = 0;
  localparam int unsigned EV_OTP        = 1;
  localparam int unsigned EV_SD_OVP     = 2;
  localparam int unsigned EV_CS_SHORT   = 3;
  localparam int unsigned EV_AUX_SHORT  = 4;
  localparam int unsigned EV_VCC_OVP    = 5;
  localparam int unsigned EV_RESTART    = 6;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // Persistence qualifiers, comparator inputs and states
  // ----------------------------------------------------------------
  localparam int unsigned NUM_Q   = 5;
  localparam int unsigned Q_BO    = 0;
  localparam int unsigned Q_LL    = 1;
  localparam int unsigned Q_TRIP  = 2;
  localparam int unsigned Q_OVP   = 3;
  localparam int unsigned Q_SHORT = 4;

  typedef struct packed {
    logic bo_on_above;
    logic bo_off_below;
    logic hl_above;
    logic ll_below;
    logic vcc_ovp;
    logic sd_ovp_above;
    logic sd_trip_below;
    logic sd_fold_below;
    logic cs_limit;
    logic cs_150;
    logic cs_setpoint;
    logic zc_above_short;
    logic valley_clock;
    logic light_load;
  } lfs_cmp_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_VALLEY,
    ST_DRIVE,
    ST_RECOVER,
    ST_LATCHED
  } lfs_state_t;

endpackage

// [hdl/lfs_sync.sv]
// Two-flop synchroniser
`timescale 1ns/10ps
module lfs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// [hdl/lfs_persist.sv]
// Persistence qualifier
`timescale 1ns/10ps
module lfs_persist (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        cond,
  input  wire logic [31:0] limit,
  output logic             hit
);

  logic [31:0] cnt_q;

  // Any drop of the condition restarts the whole interval
  always_ff @(posedge aclk) begin
    if (!aresetn || !cond) begin
      cnt_q <= 32'h0000_0000;
      hit   <= 1'b0;
    end else if (cnt_q + 32'h0000_0001 >= limit) begin
      hit   <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

endmodule

// [tb/lfs_sequencer_asserts.sv]
// Port-level checks of the fault sequencer
`timescale 1ns/10ps
module lfs_sequencer_asserts #(
  parameter logic [31:0] SD_DELAY = 32'h0000000A
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire lfs_pkg::lfs_cmp_t cmp_in,
  input wire logic              gate_drive,
  input wire logic [7:0]        current_ref
);
  logic        bo_seen_q;
  logic [31:0] ovp_cnt_q;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    bo_seen_q <= aresetn && (bo_seen_q || cmp_in.bo_on_above);
  end
  always_ff @(posedge aclk) begin
    ovp_cnt_q <= (aresetn && cmp_in.sd_ovp_above) ? ovp_cnt_q + 32'h1 : 32'h0;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_lim_held;
    cmp_in.cs_limit [*4];
  endsequence
  sequence s_valley_seen;
    $past(cmp_in.valley_clock, 3);
  endsequence
  AST_REF_FLOOR: assert property (current_ref >= 8'h64)
    else $error("ref under floor");
  AST_REF_STEP: assert property ((current_ref - $past(current_ref)) inside {8'h00, 8'h01, 8'hFF})
    else $error("ref jump");
  AST_LIMIT_END: assert property (s_lim_held |=> !gate_drive)
    else $error("pulse past limit");
  AST_SUPPLY_OVP: assert property (cmp_in.vcc_ovp [*4] |=> !gate_drive [*3])
    else $error("gate in supply ovp");
  AST_START_QUIET: assert property ($rose(aresetn) |-> !gate_drive [*4])
    else $error("gate after reset");
  AST_NEEDS_LINE: assert property (gate_drive |-> bo_seen_q)
    else $error("gate without line");
  AST_VALLEY_START: assert property ($rose(gate_drive) |-> s_valley_seen)
    else $error("gate off valley");
  AST_SD_OVP_STOP: assert property (ovp_cnt_q > SD_DELAY + 32'h3 |-> !gate_drive)
    else $error("gate in pin ovp");
endmodule
bind lfs_sequencer lfs_sequencer_asserts #(.SD_DELAY(SD_DELAY)) lfs_sequencer_asserts_i (
  .aclk, .aresetn, .cmp_in, .gate_drive, .current_ref);

// [tb/lfs_stage_model.sv]
// Behavioural power stage at the gate
`timescale 1ns/10ps
module lfs_stage_model (
  input  wire logic       aclk,
  input  wire logic       gate_drive,
  input  wire logic [7:0] on_len,
  output logic            valley_clock,
  output logic            cs_limit,
  output logic            zc_above_short
);
  logic [7:0] cnt_q  = 8'h00;
  logic       gate_q = 1'b0;
  always @(posedge aclk) begin
    gate_q         <= gate_drive;
    cnt_q          <= (gate_drive != gate_q) ? 8'h00 : cnt_q + 8'h01;
    cs_limit       <= gate_drive && (cnt_q >= on_len);
    // Ringing only while off; four-cycle pulses give the sync margin
    valley_clock   <= !gate_drive && cnt_q[2];
    zc_above_short <= !gate_drive && cnt_q[2];
  end
endmodule

// [tb/lfs_sequencer_bench.sv]
// Self-checking bench of the fault sequencer
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module lfs_sequencer_bench;
  logic              aclk = 1'b0;
  logic              aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic              gate_drive, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid, v, l, z;
  logic [7:0]        s_axi_awaddr, s_axi_araddr, current_ref, on_len;
  logic [31:0]       s_axi_wdata, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  lfs_pkg::lfs_cmp_t cmp, cmp_in;
  int                fail_count, samples_checked, cyc;
  always #2.5 aclk = ~aclk;
  always_comb begin
    cmp_in = cmp;
    cmp_in.valley_clock = v;
    cmp_in.cs_limit = l;
    cmp_in.zc_above_short = z;
  end
  lfs_sequencer #(.BO_BLANK(32'h32), .SD_DELAY(32'hA), .RECOVERY(32'hC8), .OTP_BLANK(32'h14))
    lfs_sequencer_i (.*);
  lfs_stage_model lfs_stage_model_i (.aclk, .gate_drive, .on_len, .valley_clock(v),
    .cs_limit(l), .zc_above_short(z));
  // ----------------------------------------------------------------
  // Bus, reset and report tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    logic aw, w;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, x, 3'h7};
    {aw, w} = 2'h3;
    do begin
      @(posedge aclk);
      if (aw && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
      {aw, w} = {aw && !s_axi_awready, w && !s_axi_wready};
    end while (aw || w);
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rx(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    `CHK($sformatf("reg %h", a), e, d & m)
  endtask
  task automatic rst();
    aresetn <= 1'b0;
    cmp <= '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic final_report();
    $display("fail_count %0d samples_checked %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, on_len} = {48'h0, 12'hF06};
    rst();
    rx(8'h00, '1, 32'h0);
    rx(8'h10, '1, 32'h0);
    rx(8'h40, '1, 32'h0);
    `CHK("rresp", 2'h2, r)
    wr(8'h40, 32'h1);
    `CHK("bresp", 2'h2, r)
    wr(8'h10, 32'h7F);
    cmp.bo_on_above <= 1'b1;
    while (!gate_drive) @(posedge aclk);
    rx(8'h04, 32'h10, 32'h10);
    cmp.vcc_ovp <= 1'b1;
    repeat (10) @(posedge aclk);
    rx(8'h08, 32'h20, 32'h20);
    `CHK("irq", 1'b1, irq)
    wr(8'h10, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    cmp.vcc_ovp <= 1'b0;
    wr(8'h0C, 32'h3F);
    rx(8'h04, 32'h7, 32'h3);
    repeat (250) @(posedge aclk);
    rx(8'h08, 32'h7F, 32'h40);
    cmp.sd_ovp_above <= 1'b1;
    repeat (30) @(posedge aclk);
    rx(8'h04, 32'h7, 32'h4);
    rx(8'h08, 32'h4, 32'h4);
    rst();
    wr(8'h00, 32'h1);
    cmp.bo_on_above <= 1'b1;
    while (!gate_drive) @(posedge aclk);
    cmp.sd_trip_below <= 1'b1;
    repeat (30) @(posedge aclk);
    rx(8'h04, 32'h7, 32'h3);
    rx(8'h08, 32'h2, 32'h2);
    cmp.sd_trip_below <= 1'b0;
    repeat (220) @(posedge aclk);
    cmp.bo_off_below <= 1'b1;
    repeat (20) @(posedge aclk);
    rx(8'h04, 32'h10, 32'h10);
    repeat (60) @(posedge aclk);
    rx(8'h04, 32'h10, 32'h0);
    rx(8'h08, 32'h1, 32'h1);
    final_report();
  end
endmodule
